// ==== logic/kpiu_filter.v ====
/*
  Debounce filter for one qualified interrupt input.
  Assumes a synchronised input and a one-cycle millisecond tick on mclk.
*/
`timescale 1ns/1ps
`include "kpiu_defs.vh"

module kpiu_filter #(
  parameter W = 6
) (
  input wire mclk,
  input wire sys_rst,
  input wire tick,
  input wire enable,
  input wire [W-1:0] interval,
  input wire rawIn,
  output reg cleanOut
);

  reg [W-1:0] cnt;
  wire [W:0] cntInc = {1'b0, cnt} + {{W{1'b0}}, 1'b1};

  // Tick phase is free running, so the settle time is N-1 to N ms
  always @(posedge mclk) begin
    if (sys_rst) begin
      cnt <= {W{1'b0}};
      cleanOut <= 1'b0;
    end else if (!enable || interval == {W{1'b0}}) begin
      cnt <= {W{1'b0}};
      cleanOut <= rawIn;
    end else if (rawIn == cleanOut) begin
      cnt <= {W{1'b0}};
    end else if (tick) begin
      if (cntInc >= {1'b0, interval}) begin
        cnt <= {W{1'b0}};
        cleanOut <= rawIn;
      end else begin
        cnt <= cntInc[W-1:0];
      end
    end
  end

endmodule

// ==== logic/kpiu_top.v ====
/*
  Keypad and pin interrupt unit: five single-pin interrupt sources and one
  keypad interrupt, with debounce, polarity, release wait, release events,
  auto repeat, sticky status, mask and one level interrupt.
  Assumes pins are asynchronous to mclk and a plain register port master.
*/
`timescale 1ns/1ps
`include "kpiu_defs.vh"

// How it works
// - Per source debounce enable, bits 8 to 12
// - Bit 13 enables keypad debounce
// - Keypad interrupt only after debounce interval
// - Debounce interval is field value in ms
// - Clear bits 0-4 clear sources; read zero
// - Clear bit 5 clears keypad; reads zero
// - Wait bit 0: re-raise right after clear
// - Wait bit 1: re-raise only after release
// - Source polarity: 0 high active, 1 low
// - Bit 15 adds debounced key release events
// - Bit 14 sets keypad active level
// - Held key repeats interrupt every N ms
// - Repeat value zero disables the repeat
// - Bits 0-7 include port-0 pins in keypad
// - Six-bit selector; 1 picks port-0 pin 0
module kpiu_top #(
  parameter TICK_CYCLES = `KPIU_MS_CYCLES,
  parameter NSRC = 5
) (
  input wire mclk,
  input wire sys_rst,
  input wire [31:0] pinIn,
  input wire [31:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [15:0] regRdData,
  output reg [4:0] srcIrq,
  output reg keypadInterrupt,
  output reg irq
);

  localparam SW = `KPIU_SEL_W;
  localparam integer TICK_LAST_N = TICK_CYCLES - 1;
  localparam [19:0] TICK_LAST = TICK_LAST_N[19:0];

  // Selector 1..32 maps to port pins in order; 0 selects nothing
  function selPin;
    input [SW-1:0] sel;
    input [31:0] pins;
    reg [SW-1:0] idx;
    begin
      idx = sel - 6'h01;
      if (sel == 6'h00 || sel > 6'h20) begin
        selPin = 1'b0;
      end else begin
        selPin = pins[idx[4:0]];
      end
    end
  endfunction

  // Polarity bit turns a low-active input into a high-active one
  function activeLvl;
    input lvl;
    input lowActive;
    begin
      activeLvl = lvl ^ lowActive;
    end
  endfunction

  reg [31:0] pinMeta;
  reg [31:0] pinSync;
  reg [SW-1:0] srcSel [0:NSRC-1];
  reg [15:0] debounceConfig;
  reg [15:0] levelCtrl;
  reg [15:0] keypadCtrl;
  reg [5:0] irqMask;
  reg [5:0] pend;
  reg [5:0] next_pend;
  reg [4:0] armed;
  reg [19:0] tickCnt;
  reg tick;
  reg keyPrev;
  reg [5:0] repCnt;
  reg [15:0] next_rdData;
  integer k;
  integer j;

  wire [4:0] srcRaw;
  wire [4:0] srcClean;
  wire keyRaw;
  wire keyClean;
  wire [5:0] repValue = keypadCtrl[`KPIU_KEY_REP_MSB:`KPIU_KEY_REP_LSB];
  wire [5:0] debValue = debounceConfig[`KPIU_DEB_VAL_MSB:0];
  wire [4:0] waitRelease = levelCtrl[`KPIU_WAIT_LSB+4:`KPIU_WAIT_LSB];
  wire [6:0] repInc = {1'b0, repCnt} + 7'h01;

  // Pins are asynchronous; only the second stage is read
  always @(posedge mclk) begin
    if (sys_rst) begin
      pinMeta <= 32'h00000000;
      pinSync <= 32'h00000000;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

  // Millisecond time base shared by every counter
  always @(posedge mclk) begin
    if (sys_rst) begin
      tickCnt <= 20'h00000;
      tick <= 1'b0;
    end else if (tickCnt >= TICK_LAST) begin
      tickCnt <= 20'h00000;
      tick <= 1'b1;
    end else begin
      tickCnt <= tickCnt + 20'h00001;
      tick <= 1'b0;
    end
  end

  // Every source has its own filter; the interval field is shared
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : srcPath
      assign srcRaw[g] = activeLvl(selPin(srcSel[g], pinSync),
        levelCtrl[`KPIU_POL_LSB+g]);
      kpiu_filter #(
        .W(6)
      ) srcFilter (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(tick),
        .enable(debounceConfig[`KPIU_DEB_EN_LSB+g]),
        .interval(debValue),
        .rawIn(srcRaw[g]),
        .cleanOut(srcClean[g])
      );
    end
  endgenerate

  // Any enabled port-0 pin at its active level counts as a pressed key
  assign keyRaw = |(keypadCtrl[`KPIU_KEY_EN_MSB:0] &
    (keypadCtrl[`KPIU_KEY_POL_BIT] ? ~pinSync[7:0] : pinSync[7:0]));

  kpiu_filter #(
    .W(6)
  ) keyFilter (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick(tick),
    .enable(debounceConfig[`KPIU_DEB_KEY_BIT]),
    .interval(debValue),
    .rawIn(keyRaw),
    .cleanOut(keyClean)
  );

  wire keyPress = keyClean & ~keyPrev;
  wire keyRelease = ~keyClean & keyPrev & keypadCtrl[`KPIU_KEY_REL_BIT];
  wire repHeld = keyClean & keyPrev & (repValue != 6'h00);
  wire repFire = repHeld & tick & (repInc >= {1'b0, repValue});
  // Press, release and repeat all feed the one keypad pending bit
  wire keyEvent = keyPress | keyRelease | repFire;

  // Previous filtered level turns the keypad level into press and release edges
  always @(posedge mclk) begin
    if (sys_rst) begin
      keyPrev <= 1'b0;
    end else begin
      keyPrev <= keyClean;
    end
  end

  // Repeat timer restarts on every press and stops on release
  always @(posedge mclk) begin
    if (sys_rst) begin
      repCnt <= 6'h00;
    end else begin
      if (!repHeld) begin
        repCnt <= 6'h00;
      end else if (tick) begin
        if (repFire) begin
          repCnt <= 6'h00;
        end else begin
          repCnt <= repInc[5:0];
        end
      end
    end
  end

  wire clrHit = regWr && (regAddr == `KPIU_CLR_ADDR);
  wire statHit = regWr && (regAddr == `KPIU_STAT_ADDR);
  wire [5:0] clrFromClear = clrHit ? regWrData[`KPIU_CLR_KEY_BIT:0] : 6'h00;
  wire [5:0] clrFromStat = statHit ? regWrData[5:0] : 6'h00;
  wire [5:0] clrVec = clrFromClear | clrFromStat;
  // A waiting source sets pend only while armed
  wire [4:0] srcSet = srcClean & armed;
  wire [5:0] setVec = {keyEvent, srcSet};

  // Set wins over a clear in the same cycle
  always @* begin
    next_pend = (pend & ~clrVec) | setVec;
  end

  // Armed drops once a waiting source is captured, returns on release
  always @(posedge mclk) begin
    if (sys_rst) begin
      armed <= 5'h1F;
    end else begin
      for (k = 0; k < NSRC; k = k + 1) begin
        if (!srcClean[k]) begin
          armed[k] <= 1'b1;
        end else if (pend[k] && waitRelease[k]) begin
          armed[k] <= 1'b0;
        end else if (!waitRelease[k]) begin
          armed[k] <= 1'b1;
        end
      end
    end
  end

  // Outputs copy next_pend so they leave flip-flops in step with pend
  always @(posedge mclk) begin
    if (sys_rst) begin
      pend <= 6'h00;
      srcIrq <= 5'h00;
      keypadInterrupt <= 1'b0;
    end else begin
      pend <= next_pend;
      srcIrq <= next_pend[4:0];
      keypadInterrupt <= next_pend[5];
    end
  end

  // Mask acts on the next pending vector so irq rises with its source
  always @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_pend & irqMask);
    end
  end

  // Register writes
  always @(posedge mclk) begin
    if (sys_rst) begin
      for (j = 0; j < NSRC; j = j + 1) begin
        srcSel[j] <= 6'h00;
      end
      debounceConfig <= `KPIU_REG_RST;
      levelCtrl <= `KPIU_REG_RST;
      keypadCtrl <= `KPIU_REG_RST;
      irqMask <= 6'h00;
    end else if (regWr) begin
      case (regAddr)
        `KPIU_SEL0_ADDR: begin
          srcSel[0] <= regWrData[SW-1:0];
        end
        `KPIU_SEL1_ADDR: begin
          srcSel[1] <= regWrData[SW-1:0];
        end
        `KPIU_SEL2_ADDR: begin
          srcSel[2] <= regWrData[SW-1:0];
        end
        `KPIU_SEL3_ADDR: begin
          srcSel[3] <= regWrData[SW-1:0];
        end
        `KPIU_SEL4_ADDR: begin
          srcSel[4] <= regWrData[SW-1:0];
        end
        `KPIU_DEB_ADDR: begin
          debounceConfig <= regWrData & 16'h3F3F;
        end
        `KPIU_LVL_ADDR: begin
          levelCtrl <= regWrData & 16'h1F1F;
        end
        `KPIU_KEY_ADDR: begin
          keypadCtrl <= regWrData;
        end
        `KPIU_MASK_ADDR: begin
          irqMask <= regWrData[5:0];
        end
        // Clear and status writes reach pend through clrVec
        default: begin
          irqMask <= irqMask;
        end
      endcase
    end
  end

  // Read mux; the clear register and unmapped addresses read zero
  always @* begin
    case (regAddr)
      `KPIU_SEL0_ADDR: begin
        next_rdData = {10'h000, srcSel[0]};
      end
      `KPIU_SEL1_ADDR: begin
        next_rdData = {10'h000, srcSel[1]};
      end
      `KPIU_SEL2_ADDR: begin
        next_rdData = {10'h000, srcSel[2]};
      end
      `KPIU_SEL3_ADDR: begin
        next_rdData = {10'h000, srcSel[3]};
      end
      `KPIU_SEL4_ADDR: begin
        next_rdData = {10'h000, srcSel[4]};
      end
      `KPIU_DEB_ADDR: begin
        next_rdData = debounceConfig;
      end
      `KPIU_CLR_ADDR: begin
        next_rdData = 16'h0000;
      end
      `KPIU_LVL_ADDR: begin
        next_rdData = levelCtrl;
      end
      `KPIU_KEY_ADDR: begin
        next_rdData = keypadCtrl;
      end
      `KPIU_STAT_ADDR: begin
        next_rdData = {10'h000, pend};
      end
      `KPIU_MASK_ADDR: begin
        next_rdData = {10'h000, irqMask};
      end
      default: begin
        next_rdData = 16'h0000;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (sys_rst) begin
      regRdData <= 16'h0000;
    end else if (regRd) begin
      regRdData <= next_rdData;
    end else begin
      regRdData <= 16'h0000;
    end
  end

endmodule

// ==== pkg/kpiu_defs.vh ====
/*
  Register map, field positions, reset values and timing for the keypad and
  pin interrupt unit. Included by the unit's design files, the checker and the bench.
*/
`ifndef KPIU_DEFS_VH
`define KPIU_DEFS_VH

`define KPIU_SEL0_ADDR 32'h50001400
`define KPIU_SEL1_ADDR 32'h50001402
`define KPIU_SEL2_ADDR 32'h50001404
`define KPIU_SEL3_ADDR 32'h50001406
`define KPIU_SEL4_ADDR 32'h50001408
`define KPIU_DEB_ADDR 32'h5000140C
`define KPIU_CLR_ADDR 32'h5000140E
`define KPIU_LVL_ADDR 32'h50001410
`define KPIU_KEY_ADDR 32'h50001412
`define KPIU_STAT_ADDR 32'h50001420
`define KPIU_MASK_ADDR 32'h50001422

`define KPIU_REG_RST 16'h0000
`define KPIU_SEL_W 6
`define KPIU_DEB_EN_LSB 8
`define KPIU_DEB_KEY_BIT 13
`define KPIU_DEB_VAL_MSB 5
`define KPIU_CLR_KEY_BIT 5
`define KPIU_WAIT_LSB 8
`define KPIU_POL_LSB 0
`define KPIU_KEY_REL_BIT 15
`define KPIU_KEY_POL_BIT 14
`define KPIU_KEY_REP_MSB 13
`define KPIU_KEY_REP_LSB 8
`define KPIU_KEY_EN_MSB 7

`define KPIU_CLK_PERIOD_NS 40
`define KPIU_MS_NS 1000000
`define KPIU_MS_CYCLES (`KPIU_MS_NS / `KPIU_CLK_PERIOD_NS)

`endif

// ==== sim/kpiu_pins.sv ====
/* Port pin model driving pinIn from the bench's target levels.
   Assumes levels change just after a rising mclk edge. */
`timescale 1ns/1ps
module kpiu_pins (
  input wire mclk,
  input wire [31:0] level,
  input wire bounce,
  output reg [31:0] pinIn
);
  reg [31:0] prev = 32'h0;
  reg [31:0] chg = 32'h0;
  reg [2:0] cnt = 3'h0;
  initial pinIn = 32'h0;
  // Changed contacts chatter for five cycles, so a filter must restart
  always @(posedge mclk) begin
    prev <= level;
    if (level != prev) begin
      cnt <= bounce ? 3'h5 : 3'h0;
      chg <= level ^ prev;
    end else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
    pinIn <= cnt[0] ? level ^ chg : level;
  end
endmodule

// ==== sim/kpiu_top_sva.sv ====
/* Checker of the unit's register port and interrupt outputs.
   Sees only kpiu_top ports; bound after the module. */
`timescale 1ns/1ps
`include "kpiu_defs.vh"
module kpiu_top_sva (
  input wire mclk,
  input wire sys_rst,
  input wire [31:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire [15:0] regRdData,
  input wire [4:0] srcIrq,
  input wire keypadInterrupt,
  input wire irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire clrW = regWr && (regAddr == `KPIU_CLR_ADDR || regAddr == `KPIU_STAT_ADDR);
  reg [15:0] lvl;
  // Shadow of the level register; only the release-wait bit is used
  always @(posedge mclk) begin
    if (sys_rst)
      lvl <= 16'h0000;
    else if (regWr && regAddr == `KPIU_LVL_ADDR)
      lvl <= regWrData;
  end
  property p_rdIdle; !regRd |=> regRdData == 16'h0000; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside read cycle");
  property p_clrRd; regRd && regAddr == `KPIU_CLR_ADDR |=> regRdData == 16'h0000; endproperty
  a_clrRd: assert property (p_clrRd) else $error("clear register read nonzero");
  property p_unmap; regRd && regAddr == 32'h50001430 |=> regRdData == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_srcHold; !clrW |=> (srcIrq & $past(srcIrq)) == $past(srcIrq); endproperty
  a_srcHold: assert property (p_srcHold) else $error("pin interrupt dropped");
  property p_keyHold; keypadInterrupt && !(clrW && regWrData[5]) |=> keypadInterrupt; endproperty
  a_keyHold: assert property (p_keyHold) else $error("keypad interrupt dropped");
  property p_keyClr; clrW && regWrData[5] |=> !keypadInterrupt; endproperty
  a_keyClr: assert property (p_keyClr) else $error("keypad clear ignored");
  property p_wait; clrW && regWrData[0] && lvl[8] |=> !srcIrq[0] [*3]; endproperty
  a_wait: assert property (p_wait) else $error("source 0 rose before release");
  property p_irqOff; srcIrq == 5'h00 && !keypadInterrupt |-> !irq; endproperty
  a_irqOff: assert property (p_irqOff) else $error("irq without pending source");
  c_src: cover property ($rose(srcIrq[0]));
  c_key: cover property ($rose(keypadInterrupt));
  c_irq: cover property ($rose(irq) && keypadInterrupt);
endmodule
bind kpiu_top kpiu_top_sva chk (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .srcIrq(srcIrq), .keypadInterrupt(keypadInterrupt), .irq(irq));

// ==== sim/testbench.sv ====
/* Self-checking bench for kpiu_top with random register traffic.
   Assumes kpiu_pins on the pins and a four-cycle millisecond tick. */
`timescale 1ns/1ps
`include "kpiu_defs.vh"
module testbench;
  localparam T = 4;
  localparam [31:0] CL = `KPIU_CLR_ADDR;
  localparam [31:0] KY = `KPIU_KEY_ADDR;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg [31:0] regAddr = 32'h0;
  reg [15:0] regWrData = 16'h0;
  reg regWr = 1'b0;
  reg regRd = 1'b0;
  reg [31:0] lv = 32'h0;
  reg bn = 1'b0;
  reg [31:0] a;
  reg [15:0] m;
  wire [31:0] pinIn;
  wire [15:0] regRdData;
  wire [4:0] srcIrq;
  wire keypadInterrupt;
  wire irq;
  wire [5:0] pend = {keypadInterrupt, srcIrq};
  integer mismatches = 0;
  integer checked = 0;
  integer seed = 32'h6BA1;
  integer i, k, n, r;
  kpiu_pins pins (.mclk(mclk), .level(lv), .bounce(bn), .pinIn(pinIn));
  kpiu_top #(.TICK_CYCLES(T)) dut (.mclk(mclk), .sys_rst(sys_rst), .pinIn(pinIn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .srcIrq(srcIrq), .keypadInterrupt(keypadInterrupt), .irq(irq));
  always #20 mclk = ~mclk;
  // Address and readable bits of the five registers the random loop writes
  function [47:0] reg_of(input integer j);
    case (j)
      0: reg_of = {`KPIU_SEL4_ADDR, 16'h003F};
      1: reg_of = {`KPIU_DEB_ADDR, 16'h3F3F};
      2: reg_of = {CL, 16'h0000};
      3: reg_of = {`KPIU_LVL_ADDR, 16'h1F1F};
      default: reg_of = {KY, 16'hFFFF};
    endcase
  endfunction
  // Debounce window: tick phase costs up to one tick, chatter and sync add more
  function integer dlo(input integer v);
    dlo = (v - 1) * T + 4;
  endfunction
  function integer dhi(input integer v);
    dhi = (v + 1) * T + 14;
  endfunction
  task test_done;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [15:0] s, input [15:0] e);
    begin
      checked = checked + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: saw %h want %h", $time, s, e);
      end
    end
  endtask
  task wr(input [31:0] ad, input [15:0] d);
    begin
      regAddr <= ad;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask
  task rd(input [31:0] ad, input [15:0] e);
    begin
      regAddr <= ad;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      @(negedge mclk);
      chk(regRdData, e);
      @(posedge mclk);
    end
  endtask
  task wt(input integer b, input integer lim);
    begin
      n = 0;
      while (pend[b] !== 1'b1) begin
        n = n + 1;
        if (n > lim) begin
          chk(1'b0, 1'b1);
          test_done;
        end
        @(posedge mclk);
      end
    end
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    for (i = 0; i < 15; i = i + 1) begin
      k = i % 5;
      {a, m} = reg_of(k);
      if (i < 5)
        rd(a, 16'h0000);
      r = $random(seed);
      // No keypad low level and no source-0 wait, so random clears never race a keypad event or the wait check
      r[14] = 1'b0;
      r[8] = 1'b0;
      wr(a, r[15:0]);
      rd(a, r[15:0] & m);
    end
    for (k = 0; k < 5; k = k + 1) begin
      {a, m} = reg_of(k);
      wr(a, 16'h0000);
    end
    wr(CL, 16'h003F);
    wr(`KPIU_MASK_ADDR, 16'h003F);
    rd(`KPIU_MASK_ADDR, 16'h003F);
    rd(32'h50001430, 16'h0000);
    $display("registers done");
    for (i = 0; i < 5; i = i + 1) begin
      wr(`KPIU_SEL0_ADDR + 2 * i, i[15:0] + 16'h1);
      lv <= 32'h1 << i;
      wt(i, 8);
      chk(srcIrq, 5'h1 << i);
      chk(irq, 1'b1);
      lv <= 32'h0;
      repeat (4) @(posedge mclk);
      wr(`KPIU_STAT_ADDR, 16'h1 << i);
      chk(srcIrq, 5'h00);
    end
    lv <= 32'h1;
    wt(0, 8);
    wr(CL, 16'h0001);
    chk(srcIrq[0], 1'b1);
    wr(`KPIU_LVL_ADDR, 16'h0100);
    wr(CL, 16'h0001);
    repeat (6) @(posedge mclk);
    chk(srcIrq[0], 1'b0);
    lv <= 32'h0;
    wr(`KPIU_LVL_ADDR, 16'h0101);
    wt(0, 8);
    wr(`KPIU_LVL_ADDR, 16'h0000);
    wr(CL, 16'h003F);
    wr(`KPIU_DEB_ADDR, 16'h0103);
    bn <= 1'b1;
    lv <= 32'h1;
    wt(0, dhi(3));
    chk(n >= dlo(3), 1'b1);
    $display("pin sources done");
    lv <= 32'h0;
    wr(KY, 16'h0002);
    wr(CL, 16'h003F);
    wr(`KPIU_DEB_ADDR, 16'h2003);
    lv <= 32'h2;
    wt(5, dhi(3));
    chk(n >= dlo(3), 1'b1);
    bn <= 1'b0;
    lv <= 32'h0;
    wr(`KPIU_DEB_ADDR, 16'h0000);
    wr(CL, 16'h0020);
    lv <= 32'h4;
    repeat (10) @(posedge mclk);
    chk(keypadInterrupt, 1'b0);
    lv <= 32'h2;
    wt(5, 8);
    wr(CL, 16'h0020);
    repeat (4 * T) @(posedge mclk);
    chk(keypadInterrupt, 1'b0);
    lv <= 32'h0;
    repeat (8) @(posedge mclk);
    chk(keypadInterrupt, 1'b0);
    wr(KY, 16'h8202);
    lv <= 32'h2;
    wt(5, 8);
    wr(CL, 16'h0020);
    wt(5, 3 * T + 4);
    wr(KY, 16'h8002);
    wr(CL, 16'h0020);
    repeat (3 * T) @(posedge mclk);
    chk(keypadInterrupt, 1'b0);
    lv <= 32'h0;
    wt(5, 8);
    wr(KY, 16'h0000);
    wr(CL, 16'h0020);
    wr(KY, 16'h4002);
    wt(5, 8);
    wr(CL, 16'h001F);
    rd(`KPIU_STAT_ADDR, 16'h0020);
    wr(`KPIU_MASK_ADDR, 16'h001F);
    chk(irq, 1'b0);
    wr(`KPIU_MASK_ADDR, 16'h0020);
    chk(irq, 1'b1);
    $display("keypad done");
    test_done;
  end
endmodule
